// *** src/one_time_enabled_watchdog.v ***
// Notes on behaviour
// [R1] 15-bit free-running up counter fed by an 8-bit prescaler off the system clock.
// [R2] counting starts only after software writes 1 to enable bit 5; the nonvolatile auto-enable [R12] also sets it.
// [R3] when enabled, counter advances once every 12 x prescaler clocks.
// [R4] writing 1 to clear bit 4 zeroes the counter; writing 0 does nothing.
// [R5] overflow raises a whole-chip reset, restarting execution from the beginning.
// [R6] enable cannot be cleared by software; only power-on reset disables it.
// [R7] control survives pin, software and watchdog resets; power-on reset gives 0x00.
// [R8] control register is write-only; reads return nothing useful.
// [R9] overflow sets watchdog reset flag bit 7, held until software clears it.
// [R10] in idle, counting continues only when idle-count bit 3 is 1.
// [R11] prescaler codes 000..111 select divide by 2, 4, 8 ... 256.
// [R12] nonvolatile auto-enable at power-up sets enable and loads idle and prescale.
// [R13] overflow after 2^15 increments: 32768 x 12 x prescaler clock periods.
// [R14] counter frozen in power-down since the clock feeding it stops.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "watchdog_defines.vh"

module one_time_enabled_watchdog #(
  parameter COUNTER_WIDTH = `COUNTER_WIDTH,
  parameter PRESCALE_WIDTH = `PRESCALE_WIDTH
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire pin_reset_n,
  input wire soft_reset,
  input wire idle_mode,
  input wire power_down,
  input wire nv_auto_enable_option,
  input wire nv_idle_option,
  input wire [2:0] nv_prescale_option,
  output reg chip_reset,
  output reg irq
);

  // control register, only reset by power-on reset (presetn)
  reg watchdog_reset_flag;
  reg watchdog_enable_bit;
  reg idle_count_bit;
  reg [2:0] prescale_sel;

  reg [`IRQ_WIDTH-1:0] irq_status;
  reg [`IRQ_WIDTH-1:0] irq_mask;

  // pin reset and straps cross in through two flops
  reg pin_meta;
  reg pin_sync;
  reg [4:0] strap_meta;
  reg [4:0] strap_sync;
  reg [1:0] strap_wait;
  reg strap_done;

  reg [3:0] reset_hold;
  reg counter_restart;

  wire tick;
  wire overflow;
  wire [COUNTER_WIDTH-1:0] count;
  wire run;
  wire setup;
  wire wr_access;
  wire write_control;
  wire write_status;
  wire write_mask;
  wire clear_request;
  wire mapped;
  reg [31:0] next_rdata;

  assign setup = psel && !penable;
  assign wr_access = psel && penable && pready && pwrite;
  assign write_control = wr_access && (paddr == `CONTROL_ADDR) && pstrb[0];
  assign write_status = wr_access && (paddr == `IRQ_STATUS_ADDR) && pstrb[0];
  assign write_mask = wr_access && (paddr == `IRQ_MASK_ADDR) && pstrb[0];
  assign clear_request = write_control && pwdata[`CLEAR_BIT]; // [R4]
  assign mapped = (paddr == `CONTROL_ADDR) || (paddr == `IRQ_STATUS_ADDR) ||
                  (paddr == `IRQ_MASK_ADDR) || (paddr == `STATE_ADDR);

  // frozen while disabled, in power-down, or in idle without the idle bit
  assign run = watchdog_enable_bit && !power_down && // [R2] [R14]
               (!idle_mode || idle_count_bit); // [R10]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      strap_meta <= 5'h00;
      strap_sync <= 5'h00;
    end else begin
      pin_meta <= pin_reset_n;
      pin_sync <= pin_meta;
      strap_meta <= {nv_auto_enable_option, nv_idle_option, nv_prescale_option};
      strap_sync <= strap_meta;
    end
  end

  // straps are loaded once, after the sync chain has settled past release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_wait <= 2'h0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      if (strap_wait == `STRAP_SYNC_CYCLES - 2'h1) begin
        strap_done <= 1'b1;
      end else begin
        strap_wait <= strap_wait + 2'h1;
      end
    end
  end

  // control register: presetn is the power-on reset; other resets leave it alone
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_reset_flag <= 1'b0; // [R7]
      watchdog_enable_bit <= 1'b0;
      idle_count_bit <= 1'b0;
      prescale_sel <= 3'h0;
    end else begin
      if (!strap_done && (strap_wait == `STRAP_SYNC_CYCLES - 2'h1) && strap_sync[4]) begin
        watchdog_enable_bit <= 1'b1; // [R12]
        idle_count_bit <= strap_sync[3]; // [R12]
        prescale_sel <= strap_sync[2:0]; // [R12]
      end else if (write_control) begin
        // enable is one-way: a written 0 is ignored
        watchdog_enable_bit <= watchdog_enable_bit | pwdata[`ENABLE_BIT]; // [R6]
        idle_count_bit <= pwdata[`IDLE_BIT];
        prescale_sel <= pwdata[`PRESCALE_MSB:`PRESCALE_LSB];
      end
      // overflow set wins over a software clear in the same cycle
      if (overflow) begin
        watchdog_reset_flag <= 1'b1; // [R9]
      end else if (write_control && !pwdata[`FLAG_BIT]) begin
        watchdog_reset_flag <= 1'b0; // [R9]
      end
    end
  end

  // chip reset pulse on overflow; pin and soft reset restart the timer too
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_hold <= 4'h0;
      chip_reset <= 1'b0;
      counter_restart <= 1'b1;
    end else begin
      if (overflow) begin
        reset_hold <= `RESET_PULSE_CYCLES; // [R5]
      end else if (reset_hold != 4'h0) begin
        reset_hold <= reset_hold - 4'h1;
      end
      chip_reset <= overflow || (reset_hold > 4'h1); // [R5]
      counter_restart <= !pin_sync || soft_reset || overflow;
    end
  end

  prescale_divider #(
    .PRESCALE_WIDTH(PRESCALE_WIDTH)
  ) u_prescale (
    .pclk(pclk),
    .presetn(presetn),
    .restart(counter_restart || clear_request || !watchdog_enable_bit), // [R4]
    .run(run),
    .prescale_sel(prescale_sel),
    .tick(tick)
  );

  wdt_counter #(
    .WIDTH(COUNTER_WIDTH)
  ) u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .restart(counter_restart || clear_request || !watchdog_enable_bit), // [R4]
    .tick(tick),
    .count(count),
    .overflow(overflow)
  );

  // interrupt status: sticky, write one to clear, set beats clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= `IRQ_RESET;
      irq_mask <= `IRQ_RESET;
      irq <= 1'b0;
    end else begin
      irq_status[`IRQ_OVERFLOW_BIT] <= overflow ||
        (irq_status[`IRQ_OVERFLOW_BIT] && !(write_status && pwdata[`IRQ_OVERFLOW_BIT]));
      irq_status[`IRQ_KICK_BIT] <= clear_request ||
        (irq_status[`IRQ_KICK_BIT] && !(write_status && pwdata[`IRQ_KICK_BIT]));
      if (write_mask) begin
        irq_mask <= pwdata[`IRQ_WIDTH-1:0];
      end
      irq <= |(irq_status & irq_mask);
    end
  end

  // read data; control reads back as zero since it is write-only
  always @* begin
    next_rdata = 32'h00000000;
    case (paddr)
      `CONTROL_ADDR: next_rdata = 32'h00000000; // [R8]
      `IRQ_STATUS_ADDR: next_rdata[`IRQ_WIDTH-1:0] = irq_status;
      `IRQ_MASK_ADDR: next_rdata[`IRQ_WIDTH-1:0] = irq_mask;
      `STATE_ADDR: begin
        next_rdata[COUNTER_WIDTH-1:0] = count;
        next_rdata[16] = watchdog_enable_bit;
        next_rdata[17] = watchdog_reset_flag;
        next_rdata[18] = run;
      end
      default: next_rdata = 32'h00000000;
    endcase
  end

  // no wait state: answer registered in setup, pready high in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : next_rdata;
      pready <= 1'b1;
      pslverr <= !mapped;
    end else begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // one_time_enabled_watchdog

// *** src/watchdog_defines.vh ***
`ifndef WATCHDOG_DEFINES_VH
`define WATCHDOG_DEFINES_VH

// register indices and byte addresses (byte address = 4 x index)
`define CONTROL_INDEX 12'h0E1
`define CONTROL_ADDR 12'h384
`define IRQ_STATUS_ADDR 12'h000
`define IRQ_MASK_ADDR 12'h004
`define STATE_ADDR 12'h008

// control register fields
`define FLAG_BIT 7
`define ENABLE_BIT 5
`define CLEAR_BIT 4
`define IDLE_BIT 3
`define PRESCALE_MSB 2
`define PRESCALE_LSB 0
`define CONTROL_RESET 8'h00

// interrupt status fields
`define IRQ_OVERFLOW_BIT 0
`define IRQ_KICK_BIT 1
`define IRQ_WIDTH 2
`define IRQ_RESET 2'h0

// timing
`define CLOCK_PERIOD_NS 25
`define BASE_DIVIDE 4'hC
`define COUNTER_WIDTH 15
`define PRESCALE_WIDTH 8
`define RESET_PULSE_CYCLES 4'h4
`define STRAP_SYNC_CYCLES 2'h3

`endif

// *** src/prescale_divider.v ***
`timescale 1ns/1ps
`include "watchdog_defines.vh"

module prescale_divider #(
  parameter PRESCALE_WIDTH = `PRESCALE_WIDTH
) (
  input wire pclk,
  input wire presetn,
  input wire restart,
  input wire run,
  input wire [2:0] prescale_sel,
  output reg tick
);

  reg [3:0] base_count;
  reg [PRESCALE_WIDTH-1:0] pre_count;
  wire [PRESCALE_WIDTH:0] wide_mask;
  wire [PRESCALE_WIDTH-1:0] mask;
  wire base_wrap;
  wire pre_wrap;

  // codes 0..7 give divide by 2..256
  // shift amount widened so code 7 does not wrap to a zero shift
  assign wide_mask = ({{PRESCALE_WIDTH{1'b0}}, 1'b1} << ({1'b0, prescale_sel} + 4'h1)) -
                     {{PRESCALE_WIDTH{1'b0}}, 1'b1}; // [R11]
  assign mask = wide_mask[PRESCALE_WIDTH-1:0];
  assign base_wrap = (base_count == (`BASE_DIVIDE - 4'h1));
  assign pre_wrap = ((pre_count & mask) == mask);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_count <= 4'h0;
      pre_count <= {PRESCALE_WIDTH{1'b0}};
      tick <= 1'b0;
    end else if (restart) begin
      base_count <= 4'h0;
      pre_count <= {PRESCALE_WIDTH{1'b0}};
      tick <= 1'b0;
    end else if (run) begin
      // one tick every 12 x prescaler clocks
      tick <= base_wrap && pre_wrap; // [R3]
      if (base_wrap) begin
        base_count <= 4'h0;
        pre_count <= pre_count + 1'b1; // [R1]
      end else begin
        base_count <= base_count + 4'h1;
      end
    end else begin
      tick <= 1'b0;
    end
  end

endmodule // prescale_divider

// *** src/wdt_counter.v ***
`timescale 1ns/1ps
`include "watchdog_defines.vh"

module wdt_counter #(
  parameter WIDTH = `COUNTER_WIDTH
) (
  input wire pclk,
  input wire presetn,
  input wire restart,
  input wire tick,
  output reg [WIDTH-1:0] count,
  output reg overflow
);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {WIDTH{1'b0}};
      overflow <= 1'b0;
    end else if (restart) begin
      count <= {WIDTH{1'b0}};
      overflow <= 1'b0;
    end else begin
      // overflow after 2^WIDTH increments
      overflow <= tick && (&count); // [R13]
      if (tick) begin
        count <= count + 1'b1; // [R1]
      end
    end
  end

endmodule // wdt_counter

// *** tb/wdt_checker.sv ***
`timescale 1ns/1ps
`include "watchdog_defines.vh"
module wdt_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire chip_reset,
  input wire irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  wire mapped = paddr == `CONTROL_ADDR || paddr == `IRQ_STATUS_ADDR ||
    paddr == `IRQ_MASK_ADDR || paddr == `STATE_ADDR;
  sequence reset_pulse;
    chip_reset [*4] ##1 !chip_reset;
  endsequence
  a_ready_after_setup: assert property (setup |=> pready) else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
  a_err_unmapped: assert property (setup && !mapped |=> pslverr) else $error("no error");
  a_err_mapped: assert property (setup && mapped |=> !pslverr) else $error("spurious error");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_control_reads_zero: assert property (pready && !pwrite && paddr == `CONTROL_ADDR
    |-> prdata == 32'h0) else $error("control read not zero");
  a_reset_pulse_len: assert property ($rose(chip_reset) |-> reset_pulse)
    else $error("chip reset pulse length");
  a_mask_off_quiet: assert property (pready && pwrite && paddr == `IRQ_MASK_ADDR &&
    pstrb[0] && pwdata[1:0] == 2'h0 |-> ##2 !irq) else $error("irq with mask clear");
endmodule // wdt_checker
bind one_time_enabled_watchdog wdt_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .chip_reset(chip_reset), .irq(irq));

// *** tb/tb_one_time_enabled_watchdog.sv ***
`timescale 1ns/1ps
`include "watchdog_defines.vh"
`define CHK(nm, e, s) begin compares++; if ((e) !== (s)) begin n_fail++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, s); end end
module tb_one_time_enabled_watchdog;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, slv, pin_reset_n = 1, soft_reset = 0, idle_mode = 0, power_down = 0;
  logic nv_auto = 0, nv_idle = 0, chip_reset, irq;
  logic [2:0] nv_ps = 0;
  int n_fail = 0, compares = 0, cyc = 0, n, t;
  always #12.5 pclk = ~pclk;
  // short counter so that an overflow is reachable within the run
  one_time_enabled_watchdog #(.COUNTER_WIDTH(6)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_reset_n(pin_reset_n),
    .soft_reset(soft_reset), .idle_mode(idle_mode), .power_down(power_down),
    .nv_auto_enable_option(nv_auto), .nv_idle_option(nv_idle),
    .nv_prescale_option(nv_ps), .chip_reset(chip_reset), .irq(irq));
  function int period(input int code);
    return `BASE_DIVIDE * (2 << code);
  endfunction
  task results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      results();
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= ($urandom & 32'hFFFFFF00) | {24'h000000, d};
    @(posedge pclk);
    penable <= 1;
    t = 0;
    do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wait_cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  initial begin
    void'($urandom(32'h5973));
    wait_cyc(4);
    presetn <= 1;
    apb(0, `IRQ_STATUS_ADDR, 0); `CHK("status", 32'h0, rd)
    apb(0, `IRQ_MASK_ADDR, 0); `CHK("mask", 32'h0, rd)
    apb(0, `CONTROL_ADDR, 0); `CHK("control", 32'h0, rd)
    wait_cyc(100);
    apb(0, `STATE_ADDR, 0); `CHK("state", 32'h0, rd)
    apb(0, 12'h100, 0); `CHK("unmapped", 1'b1, slv)
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      n = 2 + $urandom % 3;
      apb(1, `CONTROL_ADDR, 8'h30 | c[7:0]);
      wait_cyc(period(c) * n + period(c) / 2);
      apb(0, `STATE_ADDR, 0); `CHK("count", n[14:0], rd[14:0])
    end
    $display("test prescale done");
    apb(1, `CONTROL_ADDR, 8'h00);
    apb(0, `STATE_ADDR, 0); `CHK("enable", 1'b1, rd[16])
    idle_mode <= 1;
    apb(1, `CONTROL_ADDR, 8'h30);
    wait_cyc(200);
    apb(0, `STATE_ADDR, 0); `CHK("idle hold", 15'h0, rd[14:0])
    apb(1, `CONTROL_ADDR, 8'h38);
    wait_cyc(period(0) * 3 + 12);
    apb(0, `STATE_ADDR, 0); `CHK("idle run", 15'h3, rd[14:0])
    power_down <= 1;
    apb(0, `STATE_ADDR, 0);
    n = rd[14:0];
    wait_cyc(200);
    apb(0, `STATE_ADDR, 0); `CHK("power down", n[14:0], rd[14:0])
    power_down <= 0;
    idle_mode <= 0;
    $display("test idle done");
    apb(1, `CONTROL_ADDR, 8'h30);
    t = 0;
    while (chip_reset !== 1'b1 && t < 2000) begin
      @(posedge pclk);
      t++;
    end
    `CHK("overflow time", 1'b1, (t > 1500 && t < 1600))
    apb(0, `STATE_ADDR, 0); `CHK("reset flag", 1'b1, rd[17])
    apb(1, `CONTROL_ADDR, 8'h10);
    apb(0, `STATE_ADDR, 0); `CHK("flag clear", 1'b0, rd[17])
    $display("test overflow done");
    apb(1, `IRQ_MASK_ADDR, 8'h02);
    apb(1, `CONTROL_ADDR, 8'h30);
    apb(0, `IRQ_STATUS_ADDR, 0); `CHK("kick", 1'b1, rd[`IRQ_KICK_BIT])
    wait_cyc(2); `CHK("irq on", 1'b1, irq)
    apb(1, `IRQ_STATUS_ADDR, 8'h02);
    wait_cyc(2); `CHK("irq off", 1'b0, irq)
    apb(1, `IRQ_MASK_ADDR, 8'h00);
    apb(1, `CONTROL_ADDR, 8'h30);
    wait_cyc(2); `CHK("irq masked", 1'b0, irq)
    apb(1, `IRQ_STATUS_ADDR, 8'h03);
    $display("test irq done");
    pin_reset_n <= 0;
    wait_cyc(3);
    pin_reset_n <= 1;
    soft_reset <= 1;
    wait_cyc(2);
    soft_reset <= 0;
    wait_cyc(4);
    apb(0, `STATE_ADDR, 0); `CHK("kept", 1'b1, rd[16])
    $display("test warm reset done");
    nv_auto <= 1;
    nv_idle <= 1;
    nv_ps <= 3'h5;
    idle_mode <= 1;
    presetn <= 0;
    wait_cyc(4);
    presetn <= 1;
    wait_cyc(period(5) * 2 + period(5) / 2);
    apb(0, `STATE_ADDR, 0); `CHK("auto enable", 1'b1, rd[16])
    `CHK("auto count", 15'h2, rd[14:0])
    $display("test strap done");
    results();
  end
endmodule // tb_one_time_enabled_watchdog
